/* design/pesr_consts.svh */
`ifndef PESR_CONSTS_SVH
`define PESR_CONSTS_SVH

// ********************************************************************
// Frame layout
// ********************************************************************
`define PESR_HDR_BYTES      32'd32
`define PESR_DESC_BYTES     32'd32
`define PESR_DESC_SHIFT     5
`define PESR_NELEM          8
`define PESR_SLOT_W         3

// Header field byte offsets
`define PESR_HDR_TOTAL_OFS  5'd0
`define PESR_HDR_RET_OFS    5'd4
`define PESR_HDR_DEPOP_OFS  5'd8
`define PESR_HDR_RSVD_OFS   5'd12

// Descriptor field byte offsets
`define PESR_DSC_ID_OFS     5'd4
`define PESR_DSC_TYPE_OFS   5'd14
`define PESR_DSC_HLTH_OFS   5'd15
`define PESR_DSC_CAP_OFS    5'd16
`define PESR_DSC_RSVD_OFS   5'd24

// ********************************************************************
// Codes
// ********************************************************************
`define PESR_TYPE_STORAGE   8'h01
`define PESR_HLTH_NONE      8'h00
`define PESR_HLTH_AT_LIM    8'h64
`define PESR_HLTH_OUT_LO    8'h65
`define PESR_HLTH_OUT_HI    8'hcf
`define PESR_HLTH_RSVD_LO   8'hd0
`define PESR_HLTH_RSVD_HI   8'hfc
`define PESR_HLTH_DEP_ERR   8'hfd
`define PESR_HLTH_DEP_RUN   8'hfe
`define PESR_HLTH_DEP_OK    8'hff
`define PESR_CAP_UNSPEC     64'hffff_ffff_ffff_ffff
`define PESR_FILT_ALL       2'h0
`define PESR_FILT_BAD       2'h1
`define PESR_RTYPE_PHYS     2'h0
`define PESR_RTYPE_STOR     2'h1

`endif

/* design/pesr_pkg.sv */
`default_nettype none

package pesr_pkg;

  typedef struct packed {
    logic [31:0] start_elem;
    logic [31:0] alloc_len;
    logic [1:0]  filter;
    logic [1:0]  rtype;
  } pesr_req_t;

  typedef struct packed {
    logic [2:0]  slot;
    logic        present;
    logic [31:0] id;
    logic [7:0]  health;
    logic        cap_known;
    logic [63:0] cap;
  } pesr_upd_t;

  typedef struct packed {
    logic [31:0] id;
    logic [7:0]  health;
    logic [63:0] cap;
  } pesr_elem_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } pesr_byte_t;

  typedef enum logic [1:0] {
    PESR_IDLE,
    PESR_COUNT,
    PESR_SEND
  } pesr_state_t;

endpackage

`default_nettype wire

/* design/pesr_elem_table.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pesr_consts.svh"

module pesr_elem_table (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  // Element update
  input  wire logic                  upd_we,
  input  wire pesr_pkg::pesr_upd_t   upd,
  // Search
  input  wire logic [31:0]           thr,
  input  wire logic [1:0]            filter,
  input  wire logic [1:0]            rtype,
  output logic [`PESR_NELEM-1:0]     match_vec,
  output logic                       hit,
  output pesr_pkg::pesr_elem_t       hit_elem,
  output logic [31:0]                depop_id
);

  pesr_pkg::pesr_elem_t    tbl_r   [`PESR_NELEM];
  pesr_pkg::pesr_elem_t    tbl_nxt [`PESR_NELEM];
  logic [`PESR_NELEM-1:0]  pres_r;
  logic [`PESR_NELEM-1:0]  pres_nxt;

  // Reserved health codes never leave the block
  function automatic logic [7:0] clean_health(input logic [7:0] h);
    if (h >= `PESR_HLTH_RSVD_LO && h <= `PESR_HLTH_RSVD_HI) begin
      clean_health = `PESR_HLTH_NONE;
    end else begin
      clean_health = h;
    end
  endfunction

  function automatic logic selected(input logic [7:0] h, input logic [1:0] f, input logic [1:0] rt);
    logic rt_ok;
    logic f_ok;
    // Every element held here is a storage element, so both report types take all
    rt_ok = (rt == `PESR_RTYPE_PHYS) || (rt == `PESR_RTYPE_STOR);
    f_ok  = (f == `PESR_FILT_ALL) ||
            ((f == `PESR_FILT_BAD) && ((h >= `PESR_HLTH_OUT_LO && h <= `PESR_HLTH_OUT_HI) ||
                                      h >= `PESR_HLTH_DEP_ERR));
    selected = rt_ok && f_ok;
  endfunction

  // ********************************************************************
  // Storage
  // ********************************************************************
  always_comb begin
    tbl_nxt  = tbl_r;
    pres_nxt = pres_r;
    if (upd_we) begin
      // Identifier zero cannot be reported, so such an entry is dropped
      pres_nxt[upd.slot]       = upd.present && (upd.id != 32'h0000_0000);
      tbl_nxt[upd.slot].id     = upd.id;
      tbl_nxt[upd.slot].health = clean_health(upd.health);
      tbl_nxt[upd.slot].cap    = upd.cap_known ? upd.cap : `PESR_CAP_UNSPEC;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pres_r <= '0;
      for (int i = 0; i < `PESR_NELEM; i++) begin
        tbl_r[i] <= '0;
      end
    end else begin
      pres_r <= pres_nxt;
      tbl_r  <= tbl_nxt;
    end
  end

  // ********************************************************************
  // Search for the lowest matching identifier
  // ********************************************************************
  always_comb begin
    match_vec = '0;
    hit       = 1'b0;
    hit_elem  = '0;
    depop_id  = 32'h0000_0000;
    for (int i = 0; i < `PESR_NELEM; i++) begin
      match_vec[i] = pres_r[i] && selected(tbl_r[i].health, filter, rtype) && (tbl_r[i].id >= thr);
      if (match_vec[i] && (!hit || tbl_r[i].id < hit_elem.id)) begin
        hit      = 1'b1;
        hit_elem = tbl_r[i];
      end
      if (pres_r[i] && tbl_r[i].health == `PESR_HLTH_DEP_RUN && depop_id == 32'h0000_0000) begin
        depop_id = tbl_r[i].id;
      end
    end
  end

endmodule // pesr_elem_table
`default_nettype wire

/* design/pesr_desc_fmt.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pesr_consts.svh"

module pesr_desc_fmt (
  // Descriptor source
  input  wire pesr_pkg::pesr_elem_t  elem,
  input  wire logic [4:0]            idx,
  // Formatted byte
  output logic [7:0]                 dbyte
);

  logic [4:0] rel;

  always_comb begin
    rel   = 5'h00;
    dbyte = 8'h00;
    if (idx >= `PESR_DSC_ID_OFS && idx < `PESR_DSC_ID_OFS + 5'd4) begin
      rel   = idx - `PESR_DSC_ID_OFS;
      dbyte = elem.id[8'd31 - {rel[1:0], 3'b000} -: 8];
    end else if (idx == `PESR_DSC_TYPE_OFS) begin
      dbyte = `PESR_TYPE_STORAGE;
    end else if (idx == `PESR_DSC_HLTH_OFS) begin
      dbyte = elem.health;
    end else if (idx >= `PESR_DSC_CAP_OFS && idx < `PESR_DSC_RSVD_OFS) begin
      rel   = idx - `PESR_DSC_CAP_OFS;
      dbyte = elem.cap[8'd63 - {rel[2:0], 3'b000} -: 8];
    end
  end

endmodule // pesr_desc_fmt
`default_nettype wire

/* design/pesr_framer.sv */
// Summary of operation
// - 32-byte header, then 32-byte descriptors
// - Header total counts selected elements from start
// - Total count ignores allocation length
// - Header returned count is whole descriptors sent
// - Header names the depopulating element, else zero
// - Descriptors go out in ascending identifier order
// - Descriptor layout: id, type, health, capacity
// - Every emitted identifier is non-zero
// - Type byte is 01h, storage element
// - Health code ranges; reserved codes never emitted
// - FDh, FEh, FFh report depopulation progress
// - Only a subset of healthy codes needed
// - Capacity lost, all-ones when unspecified
// - Filter 00b all, 01b only unhealthy
// - Short answer; host re-asks with higher start
`timescale 1ns/1ps
`default_nettype none
`include "pesr_consts.svh"

module pesr_framer (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  // Element table update
  input  wire logic                  upd_valid,
  input  wire pesr_pkg::pesr_upd_t   upd,
  output logic                       upd_ready,
  // Status request
  input  wire logic                  req_valid,
  input  wire pesr_pkg::pesr_req_t   req,
  output logic                       req_ready,
  // Data-in byte stream
  output logic                       dout_valid,
  output pesr_pkg::pesr_byte_t       dout,
  input  wire logic                  dout_ready,
  output logic                       resp_done
);

  // ********************************************************************
  // State
  // ********************************************************************
  pesr_pkg::pesr_state_t   state_r,   state_nxt;
  pesr_pkg::pesr_req_t     req_r,     req_nxt;
  logic [31:0]             thr_r,     thr_nxt;
  logic [31:0]             pos_r,     pos_nxt;
  logic [31:0]             xfer_r,    xfer_nxt;
  logic [31:0]             total_r,   total_nxt;
  logic [31:0]             ret_r,     ret_nxt;
  logic [31:0]             depop_r,   depop_nxt;
  logic                    ovld_r,    ovld_nxt;
  pesr_pkg::pesr_byte_t    obyte_r,   obyte_nxt;
  logic                    done_r,    done_nxt;
  logic                    rdy_r,     rdy_nxt;

  logic [`PESR_NELEM-1:0]  match_vec;
  logic                    hit;
  pesr_pkg::pesr_elem_t    hit_elem;
  logic [31:0]             depop_id;
  logic [7:0]              desc_byte;
  logic [7:0]              cur_byte;
  logic                    adv;
  logic                    in_desc;
  logic                    upd_we;
  logic [31:0]             full_len;
  logic [3:0]              cnt;

  function automatic logic [3:0] popcount(input logic [`PESR_NELEM-1:0] v);
    popcount = 4'h0;
    for (int i = 0; i < `PESR_NELEM; i++) begin
      popcount = popcount + {3'b000, v[i]};
    end
  endfunction

  function automatic logic [7:0] be_byte(input logic [31:0] w, input logic [1:0] b);
    be_byte = w[8'd31 - {b, 3'b000} -: 8];
  endfunction

  function automatic logic [7:0] hdr_byte(input logic [4:0] p, input logic [31:0] tot,
                                          input logic [31:0] ret, input logic [31:0] dep);
    if (p < `PESR_HDR_RET_OFS) begin
      hdr_byte = be_byte(tot, p[1:0]);
    end else if (p < `PESR_HDR_DEPOP_OFS) begin
      hdr_byte = be_byte(ret, p[1:0]);
    end else if (p < `PESR_HDR_RSVD_OFS) begin
      hdr_byte = be_byte(dep, p[1:0]);
    end else begin
      hdr_byte = 8'h00;
    end
  endfunction

  // ********************************************************************
  // Element table and descriptor formatter
  // ********************************************************************
  assign upd_we = upd_valid && rdy_r;

  pesr_elem_table u_table (
    .mclk      (mclk),
    .rstn      (rstn),
    .upd_we    (upd_we),
    .upd       (upd),
    .thr       (thr_r),
    .filter    (req_r.filter),
    .rtype     (req_r.rtype),
    .match_vec (match_vec),
    .hit       (hit),
    .hit_elem  (hit_elem),
    .depop_id  (depop_id)
  );

  pesr_desc_fmt u_fmt (
    .elem  (hit_elem),
    .idx   (pos_r[4:0]),
    .dbyte (desc_byte)
  );

  // ********************************************************************
  // Framer
  // ********************************************************************
  assign in_desc  = (pos_r >= `PESR_HDR_BYTES);
  assign adv      = (state_r == pesr_pkg::PESR_SEND) && (!ovld_r || dout_ready);
  assign cur_byte = in_desc ? desc_byte : hdr_byte(pos_r[4:0], total_r, ret_r, depop_r);
  assign cnt      = popcount(match_vec);
  assign full_len = `PESR_HDR_BYTES + {23'h0, cnt, 5'h00};

  always_comb begin
    state_nxt = state_r;
    req_nxt   = req_r;
    thr_nxt   = thr_r;
    pos_nxt   = pos_r;
    xfer_nxt  = xfer_r;
    total_nxt = total_r;
    ret_nxt   = ret_r;
    depop_nxt = depop_r;
    ovld_nxt  = ovld_r;
    obyte_nxt = obyte_r;
    done_nxt  = 1'b0;
    if (ovld_r && dout_ready) begin
      ovld_nxt = 1'b0;
      done_nxt = obyte_r.last;
    end
    unique case (state_r)
      pesr_pkg::PESR_IDLE: begin
        if (req_valid && rdy_r) begin
          req_nxt   = req;
          thr_nxt   = req.start_elem;
          state_nxt = pesr_pkg::PESR_COUNT;
        end
      end
      pesr_pkg::PESR_COUNT: begin
        // Table is frozen from here on, so header and descriptors agree
        total_nxt = {28'h0, cnt};
        depop_nxt = depop_id;
        pos_nxt   = 32'h0000_0000;
        if (req_r.alloc_len >= full_len) begin
          xfer_nxt = full_len;
          ret_nxt  = {28'h0, cnt};
        end else begin
          xfer_nxt = req_r.alloc_len;
          ret_nxt  = (req_r.alloc_len < `PESR_HDR_BYTES) ? 32'h0000_0000 :
                     ((req_r.alloc_len - `PESR_HDR_BYTES) >> `PESR_DESC_SHIFT);
        end
        if (req_r.alloc_len == 32'h0000_0000) begin
          done_nxt  = 1'b1;
          state_nxt = pesr_pkg::PESR_IDLE;
        end else begin
          state_nxt = pesr_pkg::PESR_SEND;
        end
      end
      pesr_pkg::PESR_SEND: begin
        if (adv) begin
          ovld_nxt       = 1'b1;
          obyte_nxt.data = cur_byte;
          obyte_nxt.last = (pos_r == xfer_r - 32'd1);
          pos_nxt        = pos_r + 32'd1;
          if (in_desc && pos_r[4:0] == 5'h1f) begin
            thr_nxt = hit_elem.id + 32'd1;
          end
          if (pos_r == xfer_r - 32'd1) begin
            state_nxt = pesr_pkg::PESR_IDLE;
          end
        end
      end
    endcase
    rdy_nxt = (state_nxt == pesr_pkg::PESR_IDLE) && !ovld_nxt;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= pesr_pkg::PESR_IDLE;
      req_r   <= '0;
      thr_r   <= 32'h0000_0000;
      pos_r   <= 32'h0000_0000;
      xfer_r  <= 32'h0000_0000;
      total_r <= 32'h0000_0000;
      ret_r   <= 32'h0000_0000;
      depop_r <= 32'h0000_0000;
      ovld_r  <= 1'b0;
      obyte_r <= '0;
      done_r  <= 1'b0;
      rdy_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r   <= req_nxt;
      thr_r   <= thr_nxt;
      pos_r   <= pos_nxt;
      xfer_r  <= xfer_nxt;
      total_r <= total_nxt;
      ret_r   <= ret_nxt;
      depop_r <= depop_nxt;
      ovld_r  <= ovld_nxt;
      obyte_r <= obyte_nxt;
      done_r  <= done_nxt;
      rdy_r   <= rdy_nxt;
    end
  end

  assign upd_ready  = rdy_r;
  assign req_ready  = rdy_r;
  assign dout_valid = ovld_r;
  assign dout       = obyte_r;
  assign resp_done  = done_r;

  // ********************************************************************
  // Checks
  // ********************************************************************
  logic [31:0] prev_id_r;
  logic        prev_vld_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prev_id_r  <= 32'h0000_0000;
      prev_vld_r <= 1'b0;
    end else if (state_r == pesr_pkg::PESR_COUNT) begin
      prev_vld_r <= 1'b0;
    end else if (adv && in_desc && pos_r[4:0] == 5'h1f) begin
      prev_id_r  <= hit_elem.id;
      prev_vld_r <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_len_bound: assert property (
    (state_r == pesr_pkg::PESR_SEND) |-> (pos_r < xfer_r) && (xfer_r <= req_r.alloc_len))
    else $error("transfer runs past allocation length");

  a_last_flag: assert property (
    (adv && pos_r == xfer_r - 32'd1) |=> (ovld_r && obyte_r.last) ##1 (state_r == pesr_pkg::PESR_IDLE))
    else $error("last byte not flagged at allocation end");

  a_ret_bound: assert property (
    (state_r == pesr_pkg::PESR_SEND) |-> (ret_r <= total_r) &&
      ((`PESR_HDR_BYTES + (ret_r << `PESR_DESC_SHIFT)) <= xfer_r || xfer_r < `PESR_HDR_BYTES))
    else $error("returned count exceeds what is sent");

  a_total_stable: assert property (
    (state_r == pesr_pkg::PESR_SEND) && $past(state_r == pesr_pkg::PESR_SEND) |-> $stable(total_r))
    else $error("total count changed mid transfer");

  a_id_nonzero: assert property (
    (adv && in_desc) |-> hit && (hit_elem.id != 32'h0000_0000))
    else $error("descriptor sent with no element or zero id");

  a_id_ascend: assert property (
    (adv && in_desc && pos_r[4:0] == 5'h00 && prev_vld_r) |-> (hit_elem.id > prev_id_r))
    else $error("descriptor identifiers not ascending");

  a_type_byte: assert property (
    (adv && in_desc && pos_r[4:0] == `PESR_DSC_TYPE_OFS) |=> (obyte_r.data == `PESR_TYPE_STORAGE))
    else $error("type byte is not storage element");

  a_hdr_rsvd: assert property (
    (adv && !in_desc && pos_r[4:0] >= `PESR_HDR_RSVD_OFS) |=> (obyte_r.data == 8'h00))
    else $error("reserved header byte not zero");

  a_filter_bad: assert property (
    (adv && in_desc && pos_r[4:0] == `PESR_DSC_HLTH_OFS && req_r.filter == `PESR_FILT_BAD)
      |=> (obyte_r.data >= `PESR_HLTH_OUT_LO) && !(obyte_r.data > `PESR_HLTH_OUT_HI &&
           obyte_r.data < `PESR_HLTH_DEP_ERR))
    else $error("filtered descriptor has healthy code");

  a_health_rsvd: assert property (
    (adv && in_desc && pos_r[4:0] == `PESR_DSC_HLTH_OFS)
      |=> !(obyte_r.data >= `PESR_HLTH_RSVD_LO && obyte_r.data <= `PESR_HLTH_RSVD_HI))
    else $error("reserved health code emitted");

  // Ready before the last byte has left would let a new request overwrite live state
  a_ready_idle: assert property (
    req_ready |-> (state_r == pesr_pkg::PESR_IDLE) && !dout_valid)
    else $error("ready raised while a response is pending");

  a_done_pulse: assert property (
    resp_done |=> !resp_done)
    else $error("done pulse longer than one cycle");

  a_desc_rsvd: assert property (
    (adv && in_desc && (pos_r[4:0] < `PESR_DSC_ID_OFS || pos_r[4:0] >= `PESR_DSC_RSVD_OFS ||
      (pos_r[4:0] >= `PESR_DSC_ID_OFS + 5'd4 && pos_r[4:0] < `PESR_DSC_TYPE_OFS)))
      |=> (obyte_r.data == 8'h00))
    else $error("reserved descriptor byte not zero");

endmodule // pesr_framer
`default_nettype wire

/* tb/pesr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pesr_host_model (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  // Data-in byte stream
  input  wire logic                 dout_valid,
  input  wire pesr_pkg::pesr_byte_t dout,
  output logic                      dout_ready,
  // Pacing
  input  wire logic                 slow
);
  integer               seed = 27;
  pesr_pkg::pesr_byte_t got[$];

  // A slow host drops ready at random, so every byte has to survive a stall
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dout_ready <= 1'b0;
    end else begin
      if (dout_valid && dout_ready) begin
        got.push_back(dout);
      end
      dout_ready <= slow ? (($random(seed) % 3) != 0) : 1'b1;
    end
  end
endmodule // pesr_host_model

`default_nettype wire

/* tb/phys_element_status_report_test.sv */
`timescale 1ns/1ps
`default_nettype none

module phys_element_status_report_test;
  // ****************************************************************
  // Signals and reference model state
  // ****************************************************************
  logic                 mclk      = 1'b0;
  logic                 rstn      = 1'b0;
  logic                 upd_valid = 1'b0;
  pesr_pkg::pesr_upd_t  upd       = '0;
  logic                 req_valid = 1'b0;
  pesr_pkg::pesr_req_t  req       = '0;
  logic                 slow      = 1'b0;
  logic                 upd_ready;
  logic                 req_ready;
  logic                 dout_valid;
  logic                 dout_ready;
  logic                 resp_done;
  pesr_pkg::pesr_byte_t dout;
  integer               seed        = 27;
  integer               err_total   = 0;
  integer               check_count = 0;
  logic [31:0]          m_id [8];
  logic [7:0]           m_hl [8];
  logic [63:0]          m_cap [8];
  logic                 m_pr [8]    = '{default: 1'b0};
  logic [7:0]           expq[$];
  localparam logic [31:0] IDS [8] = '{32'h40, 32'h10, 32'h2000_0000, 32'h7, 32'h300, 32'h21, 32'hffff_fff0, 32'h5};
  localparam logic [7:0]  HLS [8] = '{8'h30, 8'h64, 8'h70, 8'hcf, 8'hd5, 8'hfe, 8'hfd, 8'hff};

  always #2.5 mclk = ~mclk;

  pesr_framer i_dut (
    .mclk(mclk), .rstn(rstn),
    .upd_valid(upd_valid), .upd(upd), .upd_ready(upd_ready),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .dout_valid(dout_valid), .dout(dout), .dout_ready(dout_ready), .resp_done(resp_done)
  );

  pesr_host_model i_host (
    .mclk(mclk), .rstn(rstn), .dout_valid(dout_valid), .dout(dout), .dout_ready(dout_ready), .slow(slow)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("Checks made %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Leaves upd_valid high so that writes can go back to back
  task automatic write_elem(input logic [2:0] s, input logic p, input logic [31:0] id,
                            input logic [7:0] h, input logic k, input logic [63:0] c);
    upd_valid <= 1'b1;
    upd       <= '{slot: s, present: p, id: id, health: h, cap_known: k, cap: c};
    do @(posedge mclk); while (!upd_ready);
    m_pr[s]  = p && (id != 0);
    m_id[s]  = id;
    m_hl[s]  = (h >= 8'hd0 && h <= 8'hfc) ? 8'h00 : h;
    m_cap[s] = k ? c : 64'hffff_ffff_ffff_ffff;
  endtask

  task automatic put(input logic [63:0] v, input int nb);
    for (int k = nb - 1; k >= 0; k--) begin
      expq.push_back(k < 8 ? 8'(v >> (8 * k)) : 8'h00);
    end
  endtask

  task automatic build(input logic [31:0] st, input logic [31:0] al, input logic [1:0] f, input logic [1:0] r);
    logic [34:0] sel[$];
    logic [31:0] dep;
    logic [31:0] ret;
    longint      n;
    dep = 32'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m_pr[i] && m_hl[i] == 8'hfe) dep = m_id[i];
      if (m_pr[i] && m_id[i] >= st && r < 2 && (f == 0 || (f == 1 && ((m_hl[i] >= 8'h65 && m_hl[i] <= 8'hcf)
          || m_hl[i] >= 8'hfd)))) sel.push_back({m_id[i], 3'(i)});
    end
    sel.sort();
    n   = 32 + 32 * sel.size();
    ret = (al >= n) ? sel.size() : ((al < 32) ? 0 : (al - 32) / 32);
    expq = {};
    put(sel.size(), 4);
    put(ret, 4);
    put(dep, 4);
    put(0, 20);
    foreach (sel[j]) begin
      put(0, 4);
      put(sel[j][34:3], 4);
      put(0, 6);
      put({8'h01, m_hl[sel[j][2:0]]}, 2);
      put(m_cap[sel[j][2:0]], 8);
      put(0, 8);
    end
    while (expq.size() > al) void'(expq.pop_back());
  endtask

  task automatic ask(input logic [31:0] st, input logic [31:0] al, input logic [1:0] f, input logic [1:0] r);
    int w;
    build(st, al, f, r);
    i_host.got.delete();
    req_valid <= 1'b1;
    req       <= '{start_elem: st, alloc_len: al, filter: f, rtype: r};
    do @(posedge mclk); while (!req_ready);
    req_valid <= 1'b0;
    w = 0;
    do begin
      @(posedge mclk);
      w++;
    end while (!resp_done && w < 5000);
    check(w < 5000, 1'b1);
    check(req_ready, 1'b1);
    check(dout_valid, 1'b0);
    check(i_host.got.size(), expq.size());
    foreach (expq[j]) begin
      check(i_host.got[j], {expq[j], 1'(j == expq.size() - 1)});
    end
    @(posedge mclk);
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge mclk);
    check(upd_ready, 1'b0);
    check(dout_valid, 1'b0);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    ask(0, 64, 0, 0);
    for (int i = 0; i < 8; i++) begin
      write_elem(3'(i), 1'b1, IDS[i], HLS[i], i != 3, {IDS[i], 32'h1234_5678});
    end
    upd_valid <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 16; i++) begin
      ask(0, 1000, 2'(i), 2'(i >> 2));
    end
    // Truncation points sit on and beside the header and descriptor borders
    foreach (IDS[i]) begin
      slow <= i[0];
      ask(0, IDS[i] & 32'h1ff, 0, 0);
      ask(IDS[i] + i[0], 1000, 2'(i[1]), 0);
    end
    ask(0, 0, 0, 0);
    ask(0, 63, 0, 0);
    ask(0, 96, 0, 0);
    write_elem(3'd2, 1'b1, 32'h0, 8'h70, 1'b1, 64'h0);
    upd_valid <= 1'b0;
    @(posedge mclk);
    ask(0, 1000, 0, 0);
    for (int i = 0; i < 20; i++) begin
      write_elem(3'(i), 1'b1, ($random(seed) & 32'h0fff_fff8) | 32'(i % 8), 8'($random(seed)),
                 1'($random(seed)), {$random(seed), $random(seed)});
      upd_valid <= 1'b0;
      slow      <= 1'($random(seed));
      @(posedge mclk);
      ask($random(seed) & 32'h0fff_ffff, $random(seed) & 32'h1ff, 2'($random(seed) & 1), 0);
    end
    // A second reset empties the element table
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    foreach (m_pr[i]) m_pr[i] = 1'b0;
    repeat (2) @(posedge mclk);
    ask(0, 100, 0, 0);
    give_verdict();
  end

  // Worst case is 58 answers of under 300 bytes at a two-thirds accept rate
  initial begin
    repeat (90000) @(posedge mclk);
    err_total++;
    give_verdict();
  end
endmodule // phys_element_status_report_test

`default_nettype wire
